// ### pkg/pll_div_cfg.svh
// Constants for the reference and main divider block
//
// What this block does
// (R1) Reference divider is a 14-bit counter, ratio from bits 13:0, 1 to 16,383.
// (R2) Reference divider divides correct at every ratio for inputs up to 350 MHz.
// (R3) Test select 9 routes reference divider output to shared lock/data pin.
// (R4) Control bit 19 inserts a divide-by-2 ahead of main divider, else bypass.
// (R5) Software bypasses the divide-by-2 below 4 GHz, inserts it above.
// (R6) Main divider is 19 bits, integer or fractional mode, inputs up to 4 GHz.
// (R7) Comparison rate limits: 80 MHz mode A, 100 MHz mode B, 115 MHz integer.
// (R8) Integer mode main ratio may be any value from 16 to 524,287.
// (R9) Test select 10 routes main divider output to shared lock/data pin.
// (R10) Fractional modulus swings up to four from average; average within 20..524,283.
// (R11) With divide-by-2 in, overall ratio is even, from 40 to 1,048,566; the code allows 32 to 1,048,574 in integer mode.
// (R12) Phase comparator compares divided reference against divided VCO.
// (R13) Software picks high-gain buffer below 200 MHz, high-frequency 200 to 350.
// (R14) Bits 3:2 of modulator configuration choose fractional mode A or B.
// (R15) Fractional mode loads a new modulus once per main divider output cycle.
`ifndef PLL_DIV_CFG_SVH
`define PLL_DIV_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_REF_RATIO 6'h02
`define IDX_N_INT 6'h03
`define IDX_N_FRAC 6'h04
`define IDX_MOD_CFG 6'h06
`define IDX_PRESCALE 6'h08
`define IDX_TEST_SEL 6'h0f
`define IDX_STATUS 6'h12

// Field positions
`define FLD_FRAC_EN 0
`define FLD_MODE_HI 3
`define FLD_MODE_LO 2
`define FLD_DIV2_EN 19
`define FLD_RATE_ERR 0

// Encodings
`define MODE_B_CODE 2'h1
`define TEST_SEL_REF 5'h09
`define TEST_SEL_MAIN 5'h0a

// Reset values
`define RST_REF_RATIO 14'h0001
`define RST_N_INT 19'h00010
`define RST_N_FRAC 24'h000000
`define RST_TEST_SEL 5'h00

// Divider limits
`define N_INT_MIN 19'h00010
`define N_INT_MAX 19'h7ffff
`define N_FRAC_MIN 19'h00014
`define N_FRAC_MAX 19'h7fffb

// Timing: clock and comparison rate limits in MHz
`define CLK_MHZ 100
`define CMP_MAX_FRAC_A_MHZ 80
`define CMP_MAX_FRAC_B_MHZ 100
`define CMP_MAX_INT_MHZ 115
`define CMP_GAP_A ((`CLK_MHZ + `CMP_MAX_FRAC_A_MHZ - 1) / `CMP_MAX_FRAC_A_MHZ)
`define CMP_GAP_B ((`CLK_MHZ + `CMP_MAX_FRAC_B_MHZ - 1) / `CMP_MAX_FRAC_B_MHZ)
`define CMP_GAP_INT ((`CLK_MHZ + `CMP_MAX_INT_MHZ - 1) / `CMP_MAX_INT_MHZ)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### pkg/pll_div_pkg.sv
// Types for the reference and main divider block
`default_nettype none
package pll_div_pkg;
   typedef enum logic {DSM_A, DSM_B} dsm_mode_e;
   typedef enum logic [1:0] {CMP_IDLE, CMP_UP, CMP_DN} cmp_state_e;
   typedef struct packed {
      logic up;
      logic dn;
   } pump_s;
   typedef struct packed {
      logic frac_en;
      dsm_mode_e mode;
      logic div2_en;
      logic [18:0] n_int;
      logic [23:0] n_frac;
   } div_cfg_s;
endpackage
`default_nettype wire

// ### rtl/pll_dividers.sv
// Reference divider, prescaler, main divider, modulator and phase comparator
`include "pll_div_cfg.svh"
`default_nettype none
module pll_dividers #(
   parameter int REF_W = 14,
   parameter int N_W = 19,
   parameter int FRAC_W = 24
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic reference_clock_input_pin_i,
   input wire logic vco_input_positive_i,
   input wire logic vco_input_negative_i,
   output logic lock_flag_serial_out_pin_o,
   output pll_div_pkg::pump_s phase_comparator_o,
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   import pll_div_pkg::*;

   function automatic logic [5:0] reg_index(input logic [31:0] addr);
      reg_index = addr[7:2];
   endfunction

   function automatic logic is_mapped(input logic [31:0] addr);
      logic [5:0] i;
      i = reg_index(addr);
      is_mapped = (addr[31:8] == 24'h000000) &&
         (i == `IDX_REF_RATIO || i == `IDX_N_INT || i == `IDX_N_FRAC ||
          i == `IDX_MOD_CFG || i == `IDX_PRESCALE || i == `IDX_TEST_SEL ||
          i == `IDX_STATUS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree
   logic [2:0] ref_sync_q;
   logic [2:0] vco_sync_q;
   logic ref_lvl_q;
   logic vco_lvl_q;
   logic ref_rise;
   logic vco_rise;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_sync_q <= 3'h0;
         vco_sync_q <= 3'h0;
      end else begin
         ref_sync_q <= {ref_sync_q[1:0], reference_clock_input_pin_i};
         vco_sync_q <= {vco_sync_q[1:0], vco_input_positive_i & ~vco_input_negative_i};
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_lvl_q <= 1'b0;
         vco_lvl_q <= 1'b0;
      end else begin
         if (ref_sync_q[1] == ref_sync_q[2]) begin
            ref_lvl_q <= ref_sync_q[2];
         end
         if (vco_sync_q[1] == vco_sync_q[2]) begin
            vco_lvl_q <= vco_sync_q[2];
         end
      end
   end

   assign ref_rise = (ref_sync_q[1] == ref_sync_q[2]) && ref_sync_q[2] && !ref_lvl_q;
   assign vco_rise = (vco_sync_q[1] == vco_sync_q[2]) && vco_sync_q[2] && !vco_lvl_q;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [REF_W-1:0] ref_ratio_q;
   logic [N_W-1:0] n_int_q;
   logic [FRAC_W-1:0] n_frac_q;
   logic frac_en_q;
   logic [1:0] mode_q;
   logic div2_en_q;
   logic [4:0] test_sel_q;
   logic rate_err_q;
   div_cfg_s cfg;

   logic aw_hold_q, w_hold_q;
   logic [31:0] aw_addr_q, w_data_q;
   logic [3:0] w_strb_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic wr_go;
   logic [5:0] wr_idx;
   logic [31:0] rd_val;
   pump_s pump_q;

   assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_idx = reg_index(aw_addr_q);

   // Merged words for the registers that hold loose bits
   logic [31:0] mcfg_new;
   logic [31:0] pre_new;
   logic [31:0] tsel_new;

   assign mcfg_new = merge({28'h0, mode_q, 1'b0, frac_en_q}, w_data_q, w_strb_q);
   assign pre_new = merge({12'h0, div2_en_q, 19'h0}, w_data_q, w_strb_q);
   assign tsel_new = merge({27'h0, test_sel_q}, w_data_q, w_strb_q);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 32'h0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && awready_q) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid_i && wready_q) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
            wready_q <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_ratio_q <= `RST_REF_RATIO;
         n_int_q <= `RST_N_INT;
         n_frac_q <= `RST_N_FRAC;
         frac_en_q <= 1'b0;
         mode_q <= 2'h0;
         div2_en_q <= 1'b0;
         test_sel_q <= `RST_TEST_SEL;
      end else if (wr_go) begin
         case (wr_idx)
            `IDX_REF_RATIO: ref_ratio_q <= REF_W'(merge(32'(ref_ratio_q), w_data_q, w_strb_q));
            `IDX_N_INT: n_int_q <= N_W'(merge(32'(n_int_q), w_data_q, w_strb_q));
            `IDX_N_FRAC: n_frac_q <= FRAC_W'(merge(32'(n_frac_q), w_data_q, w_strb_q));
            `IDX_MOD_CFG: begin
               frac_en_q <= mcfg_new[`FLD_FRAC_EN];
               mode_q <= mcfg_new[`FLD_MODE_HI:`FLD_MODE_LO]; // R14
            end
            `IDX_PRESCALE: div2_en_q <= pre_new[`FLD_DIV2_EN]; // R4
            `IDX_TEST_SEL: test_sel_q <= tsel_new[4:0];
            default: ;
         endcase
      end
   end

   assign cfg.frac_en = frac_en_q;
   assign cfg.mode = (mode_q == `MODE_B_CODE) ? DSM_B : DSM_A; // R14
   assign cfg.div2_en = div2_en_q;
   assign cfg.n_int = n_int_q;
   assign cfg.n_frac = n_frac_q;

   always_comb begin
      rd_val = 32'h0;
      case (reg_index(s_axi_araddr_i))
         `IDX_REF_RATIO: rd_val = 32'(ref_ratio_q);
         `IDX_N_INT: rd_val = 32'(n_int_q);
         `IDX_N_FRAC: rd_val = 32'(n_frac_q);
         `IDX_MOD_CFG: rd_val = {28'h0, mode_q, 1'b0, frac_en_q};
         `IDX_PRESCALE: rd_val = {12'h0, div2_en_q, 19'h0};
         `IDX_TEST_SEL: rd_val = {27'h0, test_sel_q};
         `IDX_STATUS: rd_val = {28'h0, frac_en_q, pump_q.dn, pump_q.up, rate_err_q};
         default: rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid_i && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= is_mapped(s_axi_araddr_i) ? rd_val : 32'h0;
            rresp_q <= is_mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference divider; ratio zero is treated as one
   logic [REF_W-1:0] ref_cnt_q;
   logic [REF_W-1:0] ref_ratio_eff;
   logic ref_pulse_q;

   assign ref_ratio_eff = (ref_ratio_q == '0) ? REF_W'(1) : ref_ratio_q; // R1

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_cnt_q <= `RST_REF_RATIO;
         ref_pulse_q <= 1'b0;
      end else begin
         ref_pulse_q <= 1'b0;
         // Every qualified edge counts, so no ratio can skip one
         if (ref_rise) begin // R2
            if (ref_cnt_q <= REF_W'(1)) begin
               ref_cnt_q <= ref_ratio_eff; // R1
               ref_pulse_q <= 1'b1;
            end else begin
               ref_cnt_q <= ref_cnt_q - REF_W'(1);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Optional divide-by-2 ahead of the main divider
   logic half_q;
   logic pre_pulse;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half_q <= 1'b0;
      end else if (vco_rise && cfg.div2_en) begin
         half_q <= ~half_q;
      end
   end

   // Doubling the count keeps the overall ratio even
   assign pre_pulse = cfg.div2_en ? (vco_rise && half_q) : vco_rise; // R4 R11

   ////////////////////////////////////////////////////////////////////////
   // Fractional modulator: first order for mode A, two-stage cascade for B
   logic [FRAC_W-1:0] acc1_q, acc2_q;
   logic c2_prev_q;
   logic [FRAC_W:0] sum1, sum2;
   logic signed [3:0] dither;
   logic [N_W-1:0] n_clamped;
   logic [N_W-1:0] n_mod;
   logic [N_W-1:0] n_cnt_q;
   logic n_pulse_q;
   logic n_wrap;

   assign sum1 = {1'b0, acc1_q} + {1'b0, cfg.n_frac};
   assign sum2 = {1'b0, acc2_q} + {1'b0, sum1[FRAC_W-1:0]};

   always_comb begin
      if (!cfg.frac_en) begin
         dither = 4'sh0;
      end else if (cfg.mode == DSM_B) begin
         dither = $signed({3'h0, sum1[FRAC_W]}) + $signed({3'h0, sum2[FRAC_W]}) -
            $signed({3'h0, c2_prev_q});
      end else begin
         dither = $signed({3'h0, sum1[FRAC_W]});
      end
   end

   always_comb begin
      if (cfg.frac_en) begin
         n_clamped = (cfg.n_int < `N_FRAC_MIN) ? `N_FRAC_MIN :
            (cfg.n_int > `N_FRAC_MAX) ? `N_FRAC_MAX : cfg.n_int; // R10
      end else begin
         n_clamped = (cfg.n_int < `N_INT_MIN) ? `N_INT_MIN : cfg.n_int; // R8
      end
   end

   // Dither stays within -1..+2, inside the four-count swing
   assign n_mod = N_W'($signed({1'b0, n_clamped}) + 20'(dither)); // R10
   assign n_wrap = pre_pulse && (n_cnt_q <= N_W'(1));

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc1_q <= '0;
         acc2_q <= '0;
         c2_prev_q <= 1'b0;
      end else if (!cfg.frac_en) begin
         acc1_q <= '0;
         acc2_q <= '0;
         c2_prev_q <= 1'b0;
      end else if (n_wrap) begin // R15
         acc1_q <= sum1[FRAC_W-1:0];
         acc2_q <= sum2[FRAC_W-1:0];
         c2_prev_q <= sum2[FRAC_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main divider, 19-bit down counter reloaded at each output cycle
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         n_cnt_q <= `RST_N_INT;
         n_pulse_q <= 1'b0;
      end else begin
         n_pulse_q <= 1'b0;
         if (n_wrap) begin
            n_cnt_q <= n_mod; // R6 R15
            n_pulse_q <= 1'b1;
         end else if (pre_pulse) begin
            n_cnt_q <= n_cnt_q - N_W'(1); // R6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase comparator: tri-state up/down from the two divided edges
   cmp_state_e cmp_q, cmp_d;

   always_comb begin
      cmp_d = cmp_q;
      case (cmp_q)
         CMP_IDLE: begin
            if (ref_pulse_q && !n_pulse_q) begin
               cmp_d = CMP_UP;
            end else if (n_pulse_q && !ref_pulse_q) begin
               cmp_d = CMP_DN;
            end
         end
         CMP_UP: if (n_pulse_q) cmp_d = CMP_IDLE;
         CMP_DN: if (ref_pulse_q) cmp_d = CMP_IDLE;
         default: cmp_d = CMP_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmp_q <= CMP_IDLE;
         pump_q <= '0;
      end else begin
         cmp_q <= cmp_d; // R12
         pump_q.up <= (cmp_d == CMP_UP);
         pump_q.dn <= (cmp_d == CMP_DN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparison rate watch; sticky, write one to clear, a new event wins
   logic [7:0] gap_q;
   logic [7:0] gap_min;
   logic rate_viol;

   assign gap_min = !cfg.frac_en ? 8'(`CMP_GAP_INT) :
      (cfg.mode == DSM_B) ? 8'(`CMP_GAP_B) : 8'(`CMP_GAP_A); // R7
   assign rate_viol = ref_pulse_q && (gap_q < gap_min);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gap_q <= 8'hff;
      end else if (ref_pulse_q) begin
         gap_q <= 8'h01;
      end else if (gap_q != 8'hff) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rate_err_q <= 1'b0;
      end else if (rate_viol) begin
         rate_err_q <= 1'b1; // R7
      end else if (wr_go && wr_idx == `IDX_STATUS && w_strb_q[0] && w_data_q[`FLD_RATE_ERR]) begin
         rate_err_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Test output on the shared pin
   logic pin_q;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_q <= 1'b0;
      end else begin
         case (test_sel_q)
            `TEST_SEL_REF: pin_q <= ref_pulse_q; // R3
            `TEST_SEL_MAIN: pin_q <= n_pulse_q; // R9
            default: pin_q <= 1'b0;
         endcase
      end
   end

   assign lock_flag_serial_out_pin_o = pin_q;
   assign phase_comparator_o = pump_q;
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign s_axi_rvalid_o = rvalid_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   a_ref_reload: assert property ((ref_rise && ref_cnt_q <= REF_W'(1)) |=> // R1
      (ref_pulse_q && ref_cnt_q == $past(ref_ratio_eff)))
      else $error("reference divider did not reload its ratio");
   a_ref_count_down: assert property ((ref_rise && ref_cnt_q > REF_W'(1)) |=> // R2
      (!ref_pulse_q && ref_cnt_q == $past(ref_cnt_q) - REF_W'(1)))
      else $error("reference divider missed an input edge");
   a_test_ref_pin: assert property ((test_sel_q == `TEST_SEL_REF && ref_pulse_q) |=> pin_q) // R3
      else $error("reference output not on test pin");
   a_half_stage: assert property ((cfg.div2_en && vco_rise && !half_q) |-> // R4
      (!pre_pulse ##1 half_q))
      else $error("divide-by-2 stage passed a skipped edge");
   a_main_reload: assert property ((n_wrap && !cfg.frac_en) |=> // R6
      (n_pulse_q && n_cnt_q == $past(n_clamped)))
      else $error("main divider reload wrong in integer mode");
   a_int_floor: assert property (!cfg.frac_en |-> (n_mod >= `N_INT_MIN)) // R8
      else $error("integer modulus below floor");
   a_frac_swing: assert property (cfg.frac_en |-> // R10
      (n_mod + N_W'(4) >= n_clamped && n_mod <= n_clamped + N_W'(4) &&
       n_clamped >= `N_FRAC_MIN && n_clamped <= `N_FRAC_MAX))
      else $error("fractional modulus outside swing");
   a_test_main_pin: assert property ((test_sel_q == `TEST_SEL_MAIN && n_pulse_q) |=> pin_q) // R9
      else $error("main divider output not on test pin");
   a_pump_exclusive: assert property ((!(pump_q.up && pump_q.dn)) and // R12
      ((ref_pulse_q && !n_pulse_q && cmp_q == CMP_IDLE) |=> pump_q.up))
      else $error("phase comparator state wrong");
   a_rate_flag: assert property (rate_viol |=> rate_err_q) // R7
      else $error("rate violation not flagged");
   a_frac_step: assert property ((n_wrap && cfg.frac_en) |=> // R15
      (acc1_q == $past(sum1[FRAC_W-1:0])))
      else $error("modulator did not step on divider wrap");

   c_ref_pulse: cover property (ref_pulse_q ##[1:50] ref_pulse_q);
   c_frac_b: cover property (cfg.frac_en && cfg.mode == DSM_B && n_wrap && dither < 0);
   c_div2_wrap: cover property (cfg.div2_en && n_wrap);
   c_rate_err: cover property (rate_viol);
endmodule
`default_nettype wire

// ### dv/pll_sources.sv
// Reference oscillator and VCO model driving the divider inputs
`default_nettype none
module pll_sources #(
   parameter int REF_HALF_NS = 30,
   parameter int VCO_HALF_NS = 40
) (
   output logic ref_o,
   output logic vco_p_o,
   output logic vco_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Scaled-down rates: the input synchronisers only count below a quarter of mclk
   initial begin
      ref_o = 1'b0;
      forever #(REF_HALF_NS) ref_o = ~ref_o;
   end
   // Free-running pair, kept under the prescaler limit so the halver stays optional
   initial begin
      vco_p_o = 1'b0;
      forever #(VCO_HALF_NS) vco_p_o = ~vco_p_o;
   end
   assign vco_n_o = ~vco_p_o;
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the reference and main dividers
`include "pll_div_cfg.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pll_div_pkg::*;
   logic mclk, resetn, ref_in, vp, vn, pin;
   pump_s pump;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, r;
   int fails, comparisons, p;
   logic up_seen, dn_seen;

   pll_sources i_pll_sources (.ref_o(ref_in), .vco_p_o(vp), .vco_n_o(vn));
   pll_dividers i_pll_dividers (.mclk_i(mclk), .resetn_i(resetn),
      .reference_clock_input_pin_i(ref_in), .vco_input_positive_i(vp),
      .vco_input_negative_i(vn), .lock_flag_serial_out_pin_o(pin),
      .phase_comparator_o(pump), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Edge counts drift by one with the unrelated source phase
   task automatic near(input int got, input int exp, input string what);
      comparisons++;
      if (got < exp - 1 || got > exp + 1) begin
         fails++;
         $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] v, output logic [1:0] resp);
      int n;
      awaddr <= {24'h0, idx, 2'b00};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      resp = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50) chk(32'h0, 32'h1, "write hang");
      // One idle edge so the next call never re-drives bready in the same step
      @(posedge mclk);
   endtask

   task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] resp);
      int n;
      araddr <= {24'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 32'hx;
      resp = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            v = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50) chk(32'h0, 32'h1, "read hang");
      @(posedge mclk);
   endtask

   // Settle past the old reload, then count one-cycle pin pulses
   task automatic count(input int cyc, output int pulses);
      repeat (300) @(posedge mclk);
      pulses = 0;
      repeat (cyc) begin
         @(posedge mclk);
         if (pin === 1'b1) pulses++;
         if (pump.up === 1'b1) up_seen = 1'b1;
         if (pump.dn === 1'b1) dn_seen = 1'b1;
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hf;
      resetn = 1'b0;
      fails = 0;
      comparisons = 0;
      up_seen = 1'b0;
      dn_seen = 1'b0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rd(`IDX_REF_RATIO, d, r);
      chk(d, 32'h1, "ref ratio reset");
      rd(`IDX_N_INT, d, r);
      chk(d, 32'h10, "main ratio reset");
      rd(`IDX_TEST_SEL, d, r);
      chk(d, 32'h0, "test select reset");
      rd(6'h3f, d, r);
      chk(d, 32'h0, "unmapped read data");
      chk(32'(r), 32'(`RESP_SLVERR), "unmapped read");
      wr(6'h3f, 32'hffff_ffff, r);
      chk(32'(r), 32'(`RESP_SLVERR), "unmapped write");
      wr(`IDX_REF_RATIO, 32'hffff_ffff, r);
      rd(`IDX_REF_RATIO, d, r);
      chk(d, 32'h3fff, "ref ratio width");
      // Mid-run reset: the counter would otherwise sit in a 16383-edge reload
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rd(`IDX_REF_RATIO, d, r);
      chk(d, 32'h1, "ref ratio after reset");
      $display("test registers done");
      wr(`IDX_TEST_SEL, 32'(`TEST_SEL_REF), r);
      for (int i = 0; i < 2; i++) begin
         wr(`IDX_REF_RATIO, (i == 0) ? 32'h1 : 32'h5, r);
         count(300, p);
         near(p, (i == 0) ? 50 : 10, "ref divider pulses");
      end
      $display("test reference divider done");
      // Slow reference so that the divided VCO leads the comparator; the reference led in the runs above
      wr(`IDX_REF_RATIO, 32'd100, r);
      wr(`IDX_TEST_SEL, 32'(`TEST_SEL_MAIN), r);
      for (int h = 0; h < 2; h++) begin
         wr(`IDX_PRESCALE, 32'(h) << `FLD_DIV2_EN, r);
         count(1280, p);
         near(p, 160 / (16 * (1 + h)), "main divider pulses");
      end
      chk(32'(up_seen), 32'h1, "reference lead pumps up");
      chk(32'(dn_seen), 32'h1, "divided VCO lead pumps down");
      $display("test main divider done");
      wr(`IDX_PRESCALE, 32'h0, r);
      wr(`IDX_N_INT, 32'd20, r);
      wr(`IDX_N_FRAC, 32'h0080_0000, r);
      for (int m = 0; m < 2; m++) begin
         wr(`IDX_MOD_CFG, 32'h1 | (32'(m) << `FLD_MODE_LO), r);
         count(1640, p);
         near(p, 10, "fractional average");
         rd(`IDX_STATUS, d, r);
         chk(d & 32'h9, 32'h8, "status fractional on, no rate error");
      end
      $display("test fractional done");
      end_sim();
   end

   // Tests take about 8000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      $display("FAIL %0t watchdog expired", $time);
      end_sim();
   end
endmodule
`default_nettype wire
